// file: design/lsm_pkg.sv
// Constants, register map and field layout for the line status monitor
// How it works
// - Bit 2 of status register zero reads 1 while a line driver short is detected and 0 otherwise.
// - With its enable set, the driver fault flag raises an event on a rise, or on any change when its edge select is 1.
// - Bit 1 of status register zero reads 1 while an alarm indication signal is seen on the receive path.
// - With its enable set, the alarm indication flag raises an event on a rise, or on any change when edge select is 1.
// - Bit 0 of status register zero reads 1 while loss of signal is seen on the receive line pair.
// - With its enable set, the signal loss flag raises an event on a rise, or on any change when edge select is 1.
// - Status register zero is a read-only live view of the present condition and resets to 0; interrupt status is sticky.
// - Bits 4-0 of the attenuation register give the received attenuation code and bits 7-5 read 0.
// - With the transmit test select at 0, bits 6-0 of the transmit jitter register show the current measurement.
// - With the transmit test select at 1, it shows the peak-to-peak value since the last read, and a read restarts it.
// - With the receive test select at 0, bits 6-0 of the receive jitter register show the current measurement.
// - With the receive test select at 1, it shows the peak-to-peak value since the last read, and a read restarts it.
// - Each event sets a sticky interrupt status bit that software clears by writing 1 to it.
package lsm_pkg;
  // Wishbone geometry
  localparam int unsigned WB_ADDR_W = 8;
  localparam int unsigned WB_DATA_W = 32;
  localparam int unsigned WB_SEL_W = 4;
  localparam int unsigned IDX_W = 6;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_IRQ_EN = 6'h34;
  localparam logic [5:0] IDX_EDGE_SEL = 6'h35;
  localparam logic [5:0] IDX_STATUS_ZERO = 6'h36;
  localparam logic [5:0] IDX_ATTEN = 6'h37;
  localparam logic [5:0] IDX_TX_JIT = 6'h38;
  localparam logic [5:0] IDX_RX_JIT = 6'h39;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h3A;
  localparam logic [5:0] IDX_JIT_CTRL = 6'h3D;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h3E;
  // Flag bit positions, shared by status, enable, edge select and interrupt status
  localparam int unsigned NUM_FLAGS = 3;
  localparam int unsigned BIT_SIG_LOSS = 0;
  localparam int unsigned BIT_ALARM_IND = 1;
  localparam int unsigned BIT_DRV_FAULT = 2;
  // Jitter control bit positions
  localparam int unsigned BIT_TX_TEST = 0;
  localparam int unsigned BIT_RX_TEST = 1;
  localparam int unsigned JIT_CTRL_W = 2;
  // Field widths
  localparam int unsigned ATT_WIDTH = 5;
  localparam int unsigned JIT_WIDTH = 7;
  // Reset values
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [1:0] JIT_CTRL_RST = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

// file: design/lsm_jit_if.sv
// Interface between the status bank and one jitter peak tracker
`timescale 1ns/1ns
interface lsm_jit_if #(
  parameter int unsigned W = 7
);
  logic [W-1:0] sample;
  logic test_sel;
  logic read_pulse;
  logic [W-1:0] value;
  modport meas (input sample, input test_sel, input read_pulse, output value);
  modport bank (output sample, output test_sel, output read_pulse, input value);
endinterface

// file: design/lsm_jit_peak.sv
// Jitter reporter: current value or peak-to-peak since the last read
`timescale 1ns/1ns
module lsm_jit_peak import lsm_pkg::*; (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Measurement path
  lsm_jit_if.meas jit
);
  localparam int unsigned W = $bits(jit.sample);
  localparam logic [W-1:0] ALL_ONES = '1;
  localparam logic [W-1:0] ALL_ZERO = '0;

  logic [W-1:0] min_reg;
  logic [W-1:0] max_reg;
  logic [W-1:0] value_reg;
  logic [W-1:0] min_next;
  logic [W-1:0] max_next;
  logic [W-1:0] value_next;

  // A read restarts the window from the present sample, so the new span starts at zero
  assign min_next = jit.read_pulse ? jit.sample : ((jit.sample < min_reg) ? jit.sample : min_reg);
  assign max_next = jit.read_pulse ? jit.sample : ((jit.sample > max_reg) ? jit.sample : max_reg);
  assign value_next = jit.test_sel ? W'(max_next - min_next) : jit.sample;
  assign jit.value = value_reg;

  // Extremes start inverted so the first sample sets both
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      min_reg <= ALL_ONES;
      max_reg <= ALL_ZERO;
      value_reg <= ALL_ZERO;
    end else if (ce_i) begin
      min_reg <= min_next;
      max_reg <= max_next;
      value_reg <= value_next;
    end
  end

  AST_JIT_CURRENT: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && !jit.test_sel) |=> (jit.value == $past(jit.sample)))
    else $error("jitter current value not shown");
  AST_JIT_RESTART: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && jit.read_pulse && jit.test_sel) |=> (jit.value == ALL_ZERO))
    else $error("peak-to-peak not restarted by read");
  AST_JIT_GROWS: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && jit.test_sel && !jit.read_pulse && $past(ce_i) && $past(jit.test_sel))
      |=> (jit.value >= $past(jit.value)))
    else $error("peak-to-peak shrank without a read");
endmodule

// file: design/lsm_line_status.sv
// Line status and jitter register bank with Wishbone slave and interrupt
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
module lsm_line_status import lsm_pkg::*; #(
  parameter int unsigned JIT_W = JIT_WIDTH,
  parameter int unsigned ATT_W = ATT_WIDTH
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [WB_SEL_W-1:0] wb_sel_i,
  input wire logic [WB_DATA_W-1:0] wb_dat_i,
  output logic [WB_DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog detector levels, asynchronous
  input wire logic drv_short_i,
  input wire logic alarm_ind_i,
  input wire logic sig_loss_i,
  // Measurement words, on clock_i
  input wire logic [ATT_W-1:0] line_attenuation_code_i,
  input wire logic [JIT_W-1:0] tx_jitter_value_i,
  input wire logic [JIT_W-1:0] rx_jitter_value_i,
  // Interrupt
  output logic irq_o
);
  logic [NUM_FLAGS-1:0] raw_flags;
  logic [NUM_FLAGS-1:0] sync1_reg;
  logic [NUM_FLAGS-1:0] flag_reg;
  logic [NUM_FLAGS-1:0] flag_prev_reg;
  logic [NUM_FLAGS-1:0] irq_en_reg;
  logic [NUM_FLAGS-1:0] edge_sel_reg;
  logic [NUM_FLAGS-1:0] int_stat_reg;
  logic [NUM_FLAGS-1:0] int_stat_next;
  logic [NUM_FLAGS-1:0] evt;
  logic [NUM_FLAGS-1:0] clr_bits;
  logic [JIT_CTRL_W-1:0] jit_ctrl_reg;
  logic [ATT_W-1:0] att_reg;
  logic ack_reg;
  logic [WB_DATA_W-1:0] dat_reg;
  logic [WB_DATA_W-1:0] rd_word;
  logic [IDX_W-1:0] idx;
  logic req_take;
  logic wr_take;
  logic rd_take;
  logic hit_irq_en;
  logic hit_edge_sel;
  logic hit_status_zero;
  logic hit_atten;
  logic hit_tx_jit;
  logic hit_rx_jit;
  logic hit_irq_status;
  logic hit_jit_ctrl;
  logic hit_irq_clear;

  lsm_jit_if #(.W(JIT_W)) tx_jit ();
  lsm_jit_if #(.W(JIT_W)) rx_jit ();

  // Detector pins in their bit order
  assign raw_flags[BIT_SIG_LOSS] = sig_loss_i;
  assign raw_flags[BIT_ALARM_IND] = alarm_ind_i;
  assign raw_flags[BIT_DRV_FAULT] = drv_short_i;

  // Two-stage synchroniser; the status view is the live second stage, never a latched history
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= FLAGS_RST;
      flag_reg <= FLAGS_RST;
      flag_prev_reg <= FLAGS_RST;
    end else if (ce_i) begin
      sync1_reg <= raw_flags;
      flag_reg <= sync1_reg;
      flag_prev_reg <= flag_reg;
    end
  end

  // Attenuation code held in a flop so read data never sees a mid-cycle change
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      att_reg <= '0;
    end else if (ce_i) begin
      att_reg <= line_attenuation_code_i;
    end
  end

  // Bus decode; the word index is address bits 7-2, so the two low address bits are ignored
  assign idx = wb_adr_i[WB_ADDR_W-1:2];
  assign req_take = ce_i & wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_take = req_take & wb_we_i & wb_sel_i[0];
  assign rd_take = req_take & ~wb_we_i;
  assign hit_irq_en = (idx == IDX_IRQ_EN);
  assign hit_edge_sel = (idx == IDX_EDGE_SEL);
  assign hit_status_zero = (idx == IDX_STATUS_ZERO);
  assign hit_atten = (idx == IDX_ATTEN);
  assign hit_tx_jit = (idx == IDX_TX_JIT);
  assign hit_rx_jit = (idx == IDX_RX_JIT);
  assign hit_irq_status = (idx == IDX_IRQ_STATUS);
  assign hit_jit_ctrl = (idx == IDX_JIT_CTRL);
  assign hit_irq_clear = (idx == IDX_IRQ_CLEAR);

  // Jitter trackers; a read of a jitter register restarts its peak window at the accepting edge
  assign tx_jit.sample = tx_jitter_value_i;
  assign tx_jit.test_sel = jit_ctrl_reg[BIT_TX_TEST];
  assign tx_jit.read_pulse = rd_take & hit_tx_jit;
  assign rx_jit.sample = rx_jitter_value_i;
  assign rx_jit.test_sel = jit_ctrl_reg[BIT_RX_TEST];
  assign rx_jit.read_pulse = rd_take & hit_rx_jit;

  lsm_jit_peak u_tx_jit (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .jit(tx_jit.meas)
  );

  lsm_jit_peak u_rx_jit (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .jit(rx_jit.meas)
  );

  // Read mux; status and unmapped words read zero in unused bits, clear register reads zero
  always_comb begin
    rd_word = WORD_ZERO;
    if (hit_irq_en) begin
      rd_word[NUM_FLAGS-1:0] = irq_en_reg;
    end else if (hit_edge_sel) begin
      rd_word[NUM_FLAGS-1:0] = edge_sel_reg;
    end else if (hit_status_zero) begin
      rd_word[NUM_FLAGS-1:0] = flag_reg;
    end else if (hit_atten) begin
      rd_word[ATT_W-1:0] = att_reg;
    end else if (hit_tx_jit) begin
      rd_word[JIT_W-1:0] = tx_jit.value;
    end else if (hit_rx_jit) begin
      rd_word[JIT_W-1:0] = rx_jit.value;
    end else if (hit_irq_status) begin
      rd_word[NUM_FLAGS-1:0] = int_stat_reg;
    end else if (hit_jit_ctrl) begin
      rd_word[JIT_CTRL_W-1:0] = jit_ctrl_reg;
    end
  end

  // One-cycle ack for every access, mapped or not; the ack_reg term forces a gap between requests
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= WORD_ZERO;
    end else if (ce_i) begin
      ack_reg <= req_take;
      if (rd_take) begin
        dat_reg <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Writable control; status zero, attenuation and jitter words ignore writes, interrupt status is cleared by writing 1
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_reg <= FLAGS_RST;
      edge_sel_reg <= FLAGS_RST;
      jit_ctrl_reg <= JIT_CTRL_RST;
    end else if (wr_take) begin
      if (hit_irq_en) begin
        irq_en_reg <= wb_dat_i[NUM_FLAGS-1:0];
      end
      if (hit_edge_sel) begin
        edge_sel_reg <= wb_dat_i[NUM_FLAGS-1:0];
      end
      if (hit_jit_ctrl) begin
        jit_ctrl_reg <= wb_dat_i[JIT_CTRL_W-1:0];
      end
    end
  end

  // Event per enabled flag: rise always qualifies, fall only with edge select set
  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_evt
    assign evt[i] = irq_en_reg[i] & ((flag_reg[i] & ~flag_prev_reg[i]) |
                                     (edge_sel_reg[i] & ~flag_reg[i] & flag_prev_reg[i]));

    AST_EVT_RISE: assert property (@(posedge clock_i) disable iff (rst_i)
      (ce_i && irq_en_reg[i] && flag_reg[i] && !flag_prev_reg[i]) |=> int_stat_reg[i])
      else $error("rising flag did not set interrupt status");
    AST_EVT_FALL: assert property (@(posedge clock_i) disable iff (rst_i)
      (ce_i && irq_en_reg[i] && edge_sel_reg[i] && !flag_reg[i] && flag_prev_reg[i]) |=> int_stat_reg[i])
      else $error("falling flag with any-change select did not set status");
    AST_EVT_QUIET: assert property (@(posedge clock_i) disable iff (rst_i)
      (ce_i && !int_stat_reg[i] && (!irq_en_reg[i] || (!edge_sel_reg[i] && !flag_reg[i])))
        |=> !int_stat_reg[i])
      else $error("interrupt status set without a qualifying event");
    AST_W1C: assert property (@(posedge clock_i) disable iff (rst_i)
      (wr_take && (hit_irq_status || hit_irq_clear) && wb_dat_i[i] && !evt[i]) |=> !int_stat_reg[i])
      else $error("write of one did not clear interrupt status");
  end

  // Sticky status; an event in the clearing cycle wins over the clear
  assign clr_bits = (wr_take && (hit_irq_status || hit_irq_clear)) ? wb_dat_i[NUM_FLAGS-1:0] : FLAGS_RST;
  assign int_stat_next = (int_stat_reg & ~clr_bits) | evt;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      int_stat_reg <= FLAGS_RST;
    end else if (ce_i) begin
      int_stat_reg <= int_stat_next;
    end
  end

  // Level interrupt; enable gating is applied when events are taken, so status alone drives it
  assign irq_o = |int_stat_reg;

  AST_FLAG_SYNC: assert property (@(posedge clock_i) disable iff (rst_i)
    ($past(ce_i) && $past(ce_i, 2) && $past(!rst_i) && $past(!rst_i, 2) && $past(!rst_i, 3))
      |-> (flag_reg == $past(raw_flags, 2)))
    else $error("flag does not follow detector after two stages");
  AST_STATUS_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    (rd_take && hit_status_zero) |=> (wb_ack_o && wb_dat_o == {29'h0, $past(flag_reg)}))
    else $error("status zero read data wrong");
  AST_ATTEN_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    (rd_take && hit_atten) |=> (wb_dat_o[WB_DATA_W-1:ATT_W] == '0 && wb_dat_o[ATT_W-1:0] == $past(att_reg)))
    else $error("attenuation read data wrong");
  AST_IRQ_EVT: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && (evt != FLAGS_RST)) |=> irq_o)
    else $error("interrupt not raised after event");
  AST_IRQ_LOW: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && evt == FLAGS_RST && wr_take && hit_irq_clear && (wb_dat_i[NUM_FLAGS-1:0] | ~int_stat_reg) == 3'h7)
      |=> !irq_o)
    else $error("interrupt still high after full clear");
  AST_ACK_PULSE: assert property (@(posedge clock_i) disable iff (rst_i)
    (wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
endmodule

// file: dv/lsm_detector_model.sv
// Behavioural line detectors and jitter source facing the status bank
`timescale 1ns/1ns
module lsm_detector_model #(
  parameter int unsigned JW = 7
) (
  // Clock
  input wire logic clock_i,
  // Line conditions set by the bench
  input wire logic [2:0] cond_i,
  input wire logic [4:0] att_i,
  input wire logic [JW-1:0] jit_lo_i,
  input wire logic [JW-1:0] jit_hi_i,
  input wire logic wobble_i,
  // Detector outputs
  output logic drv_short_o,
  output logic alarm_ind_o,
  output logic sig_loss_o,
  output logic [4:0] att_o,
  output logic [JW-1:0] tx_jit_o,
  output logic [JW-1:0] rx_jit_o
);
  logic phase_reg = 1'b0;
  // Levels follow the line; jitter swings between two bounds so peak-to-peak is known
  always @(posedge clock_i) begin
    phase_reg <= wobble_i ? ~phase_reg : 1'b0;
    drv_short_o <= cond_i[2];
    alarm_ind_o <= cond_i[1];
    sig_loss_o <= cond_i[0];
    att_o <= att_i;
    tx_jit_o <= phase_reg ? jit_hi_i : jit_lo_i;
    rx_jit_o <= phase_reg ? jit_lo_i : jit_hi_i;
  end
endmodule

// file: dv/test_lsm_line_status.sv
// Self-checking bench for the line status register bank
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module test_lsm_line_status;
  import lsm_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  logic wb_ack, irq;
  logic [2:0] cond = 3'h0;
  logic [4:0] att = 5'h00;
  logic [6:0] jlo = 7'h00, jhi = 7'h00;
  logic wobble = 1'b0;
  logic drv_short, alarm_ind, sig_loss;
  logic [4:0] att_w;
  logic [6:0] tx_w, rx_w;
  int errors = 0, total_checks = 0;
  logic [5:0] ridx [8] = '{IDX_IRQ_EN, IDX_EDGE_SEL, IDX_STATUS_ZERO, IDX_ATTEN, IDX_TX_JIT,
                          IDX_RX_JIT, IDX_IRQ_STATUS, IDX_JIT_CTRL};
  logic [4:0] codes [4] = '{5'h00, 5'h15, 5'h16, 5'h1F};

  lsm_line_status dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .drv_short_i(drv_short), .alarm_ind_i(alarm_ind),
    .sig_loss_i(sig_loss), .line_attenuation_code_i(att_w), .tx_jitter_value_i(tx_w),
    .rx_jitter_value_i(rx_w), .irq_o(irq));

  lsm_detector_model model (.clock_i(clock_i), .cond_i(cond), .att_i(att), .jit_lo_i(jlo),
    .jit_hi_i(jhi), .wobble_i(wobble), .drv_short_o(drv_short), .alarm_ind_o(alarm_ind),
    .sig_loss_o(sig_loss), .att_o(att_w), .tx_jit_o(tx_w), .rx_jit_o(rx_w));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One classic cycle; a dead slave is caught by the watchdog, not here
  task automatic bus(input logic we, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clock_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= wd;
    do begin
      @(posedge clock_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic expect_rd(input logic [5:0] idx, input logic [31:0] ex, input string nm);
    bus(1'b0, idx, WORD_ZERO);
    `CHK(nm, ex, rd)
  endtask

  task automatic expect_irq(input logic ex);
    @(negedge clock_i);
    `CHK("irq", ex, irq)
  endtask

  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (ridx[i]) expect_rd(ridx[i], WORD_ZERO, "reset value");
    expect_rd(6'h00, WORD_ZERO, "unmapped");
    bus(1'b1, IDX_STATUS_ZERO, 32'h0000_00FF);
    expect_rd(IDX_STATUS_ZERO, WORD_ZERO, "status write");
    $display("test reset done");
    for (int b = 0; b < 3; b++) begin
      cond <= 3'h1 << b;
      repeat (5) @(posedge clock_i);
      expect_rd(IDX_STATUS_ZERO, 32'h1 << b, "flag");
      cond <= 3'h0;
      repeat (5) @(posedge clock_i);
      expect_rd(IDX_STATUS_ZERO, WORD_ZERO, "flag gone");
    end
    expect_rd(IDX_IRQ_STATUS, WORD_ZERO, "masked events");
    $display("test flags done");
    bus(1'b1, IDX_IRQ_EN, 32'h7);
    wb_sel <= 4'hE;
    bus(1'b1, IDX_IRQ_EN, WORD_ZERO);
    wb_sel <= 4'hF;
    expect_rd(IDX_IRQ_EN, 32'h7, "lane zero off write");
    for (int b = 0; b < 3; b++) begin
      cond <= 3'h1 << b;
      repeat (5) @(posedge clock_i);
      expect_rd(IDX_IRQ_STATUS, 32'h1 << b, "rise event");
      expect_irq(1'b1);
      bus(1'b1, IDX_IRQ_STATUS, 32'h1 << b);
      cond <= 3'h0;
      repeat (5) @(posedge clock_i);
      expect_rd(IDX_IRQ_STATUS, WORD_ZERO, "fall ignored");
      expect_irq(1'b0);
    end
    bus(1'b1, IDX_EDGE_SEL, 32'h7);
    cond <= 3'h7;
    repeat (5) @(posedge clock_i);
    expect_rd(IDX_IRQ_STATUS, 32'h7, "any change rise");
    bus(1'b1, IDX_IRQ_CLEAR, 32'h7);
    expect_rd(IDX_IRQ_STATUS, WORD_ZERO, "cleared");
    cond <= 3'h0;
    repeat (5) @(posedge clock_i);
    expect_rd(IDX_IRQ_STATUS, 32'h7, "any change fall");
    expect_irq(1'b1);
    bus(1'b1, IDX_IRQ_STATUS, 32'h7);
    expect_irq(1'b0);
    $display("test interrupts done");
    foreach (codes[i]) begin
      att <= codes[i];
      repeat (3) @(posedge clock_i);
      expect_rd(IDX_ATTEN, {27'h0, codes[i]}, "attenuation");
    end
    $display("test attenuation done");
    jlo <= 7'h2A;
    jhi <= 7'h7F;
    repeat (4) @(posedge clock_i);
    expect_rd(IDX_TX_JIT, 32'h2A, "tx current");
    expect_rd(IDX_RX_JIT, 32'h7F, "rx current");
    bus(1'b1, IDX_JIT_CTRL, 32'h3);
    jlo <= 7'h05;
    wobble <= 1'b1;
    bus(1'b0, IDX_TX_JIT, WORD_ZERO);
    bus(1'b0, IDX_RX_JIT, WORD_ZERO);
    repeat (6) @(posedge clock_i);
    expect_rd(IDX_TX_JIT, 32'h7A, "tx peak");
    expect_rd(IDX_RX_JIT, 32'h7A, "rx peak");
    wobble <= 1'b0;
    repeat (3) @(posedge clock_i);
    bus(1'b0, IDX_TX_JIT, WORD_ZERO);
    bus(1'b0, IDX_RX_JIT, WORD_ZERO);
    repeat (6) @(posedge clock_i);
    expect_rd(IDX_TX_JIT, WORD_ZERO, "tx restart");
    expect_rd(IDX_RX_JIT, WORD_ZERO, "rx restart");
    $display("test jitter done");
    print_verdict();
  end
endmodule
